// [tcs_engine.v]
// Transmit control structure engine: holds the control memory in which software builds
// per-connection structures and processes one structure per request into a cell header
// and a circular buffer address. Assumes an Avalon-MM master on the same clock and a
// TDM write pointer input from logic on the same clock.
//
// Overview of operation
// - Engine stores write pointer minus its own read pointer in the offset field.
// - Initialized flag reads 0 uninitialized, 1 initialized; software writes it 0.
// - Pointer-byte nibble 0 means no pointers, 8 means pointer in cell zero.
// - A set PTI least significant bit marks the cell as OAM type.
// - Entry valid flag 0 means invalid, 1 means usable buffer address.
// - Entry gives buffer address bits 20:6, added to the programmed buffer base.
// - Entry addresses are start pointer bits 20:8, entry field, then a zero bit.
// - Header fields GFC, VPI, VCI, PTI, CLP are held per structure and sent.
// - A structure is ignored until its active bit is one.
// - Entry field is byte offset bits 7:0 shifted right by one.
`timescale 1ns/1ps
`include "tcs_consts.vh"
module tcs_engine #(
   parameter MEM_AW = 10
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [11:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire [7:0] tdm_wr_ptr_i,
   output reg [31:0] cell_hdr_o,
   output reg [7:0] cell_hec_o,
   output reg [20:0] buf_addr_o,
   output reg cell_oam_o,
   output reg pbyte_now_o,
   output reg [2:0] cell_seq_o,
   output reg [5:0] payload_size_o,
   output reg cell_valid_o
);
   // ****************************************************************
   // State machine codes and storage
   // ****************************************************************
   localparam S_IDLE = 3'h0;
   localparam S_RD = 3'h1;
   localparam S_ENT = 3'h2;
   localparam S_CHK = 3'h3;
   localparam S_WR_OFS = 3'h4;
   localparam S_WR_CUR = 3'h5;
   localparam S_FIN = 3'h6;

   reg [15:0] mem [0:(1 << MEM_AW) - 1];
   reg [15:0] w_q [0:5];
   reg [2:0] state_q;
   reg [2:0] k_q;
   reg [15:0] mem_rd_q;
   reg [20:0] sptr_q;
   reg [20:0] base_q;
   reg st_done_q, st_inact_q, st_inval_q, st_init_q;
   reg [7:0] ofs_q;
   reg [5:0] rdptr_q;
   reg bus_ph_q;
   reg [MEM_AW-1:0] idx;
   reg mem_we;
   reg [15:0] mem_wd;

   wire [6:0] first_ent = w_q[`TCS_W_ENTRY][15:9];
   wire [6:0] last_ent = w_q[`TCS_W_ENTRY][7:1];
   wire [6:0] cur_ent = w_q[`TCS_W_CUR][15:9];
   wire [5:0] psz = w_q[`TCS_W_SIZE][5:0];
   wire [2:0] seq = w_q[`TCS_W_CUR][8:6];
   wire [3:0] psel = w_q[`TCS_W_OFS][3:0];
   // Read pointer: software value until initialized, stored value afterwards.
   wire [5:0] rd_ptr = w_q[`TCS_W_CUR][5:0];
   // Entry byte address from the upper start pointer bits and the entry field.
   wire [20:0] ent_addr = {sptr_q[20:8], cur_ent, 1'b0};
   wire [6:0] next_ent = (cur_ent == last_ent) ? first_ent : cur_ent + 7'h01;
   wire [5:0] next_ptr = rd_ptr + psz;
   wire [7:0] new_ofs = tdm_wr_ptr_i - {2'b00, next_ptr};
   wire win = avs_address_i[11] == `TCS_MEM_WIN;
   wire busy = state_q != S_IDLE;
   wire bus_req = avs_read_i | avs_write_i;

   // ****************************************************************
   // Control memory port, shared by bus and engine
   // ****************************************************************
   // Memory index and write data; the bus reaches memory only while the engine is idle.
   // The window bit itself is not part of the index, so the bus sees the lower half of memory.
   always @* begin
      idx = {1'b0, avs_address_i[MEM_AW:2]};
      mem_we = 1'b0;
      mem_wd = avs_writedata_i[15:0];
      case (state_q)
         S_IDLE: begin
            mem_we = avs_write_i & win & bus_ph_q & (&avs_byteenable_i[1:0]);
         end
         S_RD: begin
            idx = sptr_q[MEM_AW:1] + {{(MEM_AW-3){1'b0}}, k_q};
         end
         S_ENT: begin
            idx = ent_addr[MEM_AW:1];
         end
         S_WR_OFS: begin
            idx = sptr_q[MEM_AW:1] + `TCS_W_OFS;
            mem_we = 1'b1;
            // Offset stored, initialized flag set, reserved bit kept as written.
            mem_wd = {new_ofs, w_q[`TCS_W_OFS][7], 1'b1, w_q[`TCS_W_OFS][5:0]};
         end
         S_WR_CUR: begin
            idx = sptr_q[MEM_AW:1] + `TCS_W_CUR;
            mem_we = 1'b1;
            mem_wd = {next_ent, seq + 3'h1, next_ptr};
         end
         default: begin
            idx = sptr_q[MEM_AW:1];
         end
      endcase
   end

   // Synchronous single-port memory; no reset on the array itself.
   always @(posedge mclk_i) begin
      if (mem_we) begin
         mem[idx] <= mem_wd;
      end
      mem_rd_q <= mem[idx];
   end

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************
   // An access takes two cycles while the engine is idle: waitrequest high in the first, low in the second.
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_ph_q <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
         sptr_q <= `TCS_RST_ADDR;
         base_q <= `TCS_RST_ADDR;
      end else begin
         avs_waitrequest_o <= 1'b1;
         if (bus_ph_q) begin
            bus_ph_q <= 1'b0;
            // Register writes land at the edge at which the master sees waitrequest low.
            if (avs_write_i && !win && avs_address_i == `TCS_REG_SPTR) begin
               // Start pointer kept on a 16-byte boundary.
               sptr_q <= {avs_writedata_i[20:4], 4'h0};
            end else if (avs_write_i && !win && avs_address_i == `TCS_REG_BASE) begin
               base_q <= avs_writedata_i[20:0];
            end
         end else if (bus_req && !busy) begin
            bus_ph_q <= 1'b1;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= 32'h00000000;
            if (avs_read_i) begin
               if (win) begin
                  avs_readdata_o <= {16'h0000, mem[idx]};
               end else if (avs_address_i == `TCS_REG_CTRL) begin
                  avs_readdata_o <= {31'h00000000, busy};
               end else if (avs_address_i == `TCS_REG_SPTR) begin
                  avs_readdata_o <= {11'h000, sptr_q};
               end else if (avs_address_i == `TCS_REG_BASE) begin
                  avs_readdata_o <= {11'h000, base_q};
               end else if (avs_address_i == `TCS_REG_STAT) begin
                  avs_readdata_o <= {28'h0000000, st_init_q, st_inval_q, st_inact_q, st_done_q};
               end else if (avs_address_i == `TCS_REG_HDR) begin
                  avs_readdata_o <= cell_hdr_o;
               end else if (avs_address_i == `TCS_REG_BUFA) begin
                  avs_readdata_o <= {11'h000, buf_addr_o};
               end else if (avs_address_i == `TCS_REG_PTRS) begin
                  avs_readdata_o <= {18'h00000, rdptr_q, ofs_q};
               end
            end
         end
      end
   end

   // ****************************************************************
   // Structure processing engine
   // ****************************************************************
   // A write of bit 0 to the control register starts one structure pass.
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         k_q <= 3'h0;
         st_done_q <= 1'b0;
         st_inact_q <= 1'b0;
         st_inval_q <= 1'b0;
         st_init_q <= 1'b0;
         ofs_q <= 8'h00;
         rdptr_q <= 6'h00;
         cell_hdr_o <= 32'h00000000;
         cell_hec_o <= 8'h00;
         buf_addr_o <= `TCS_RST_ADDR;
         cell_oam_o <= 1'b0;
         pbyte_now_o <= 1'b0;
         cell_seq_o <= 3'h0;
         payload_size_o <= 6'h00;
         cell_valid_o <= 1'b0;
         w_q[0] <= `TCS_RST_WORD;
         w_q[1] <= `TCS_RST_WORD;
         w_q[2] <= `TCS_RST_WORD;
         w_q[3] <= `TCS_RST_WORD;
         w_q[4] <= `TCS_RST_WORD;
         w_q[5] <= `TCS_RST_WORD;
      end else begin
         cell_valid_o <= 1'b0;
         case (state_q)
            S_IDLE: begin
               k_q <= 3'h0;
               if (avs_write_i && !win && bus_ph_q && avs_address_i == `TCS_REG_CTRL && avs_writedata_i[0]) begin
                  state_q <= S_RD;
                  st_done_q <= 1'b0;
                  st_inact_q <= 1'b0;
                  st_inval_q <= 1'b0;
               end
            end
            S_RD: begin
               // Word k is addressed now; word k-1 arrives from memory.
               k_q <= k_q + 3'h1;
               if (k_q != 3'h0) begin
                  w_q[k_q - 3'h1] <= mem_rd_q;
               end
               if (k_q == 3'h1 && !mem_rd_q[`TCS_ACTIVE_BIT]) begin
                  st_inact_q <= 1'b1;
                  state_q <= S_FIN;
               end else if (k_q == `TCS_W_COUNT) begin
                  state_q <= S_ENT;
               end
            end
            S_ENT: begin
               state_q <= S_CHK;
            end
            S_CHK: begin
               st_init_q <= w_q[`TCS_W_OFS][`TCS_INIT_BIT];
               if (!mem_rd_q[`TCS_VALID_BIT]) begin
                  st_inval_q <= 1'b1;
                  state_q <= S_FIN;
               end else begin
                  // Buffer located relative to the programmed base.
                  buf_addr_o <= base_q + {mem_rd_q[14:0], 6'h00};
                  cell_hdr_o <= {w_q[`TCS_W_HDR_HI], w_q[`TCS_W_HDR_LO]};
                  cell_hec_o <= w_q[`TCS_W_ENTRY - 3'h0 + 3'h1][15:8];
                  cell_oam_o <= w_q[`TCS_W_HDR_LO][`TCS_PTI_LSB_BIT];
                  // One-hot nibble: bit 3 selects cell 0, bit 0 selects cell 6.
                  pbyte_now_o <= ~seq[0] & psel[3 - seq[2:1]];
                  cell_seq_o <= seq;
                  payload_size_o <= psz;
                  state_q <= S_WR_OFS;
               end
            end
            S_WR_OFS: begin
               ofs_q <= new_ofs;
               rdptr_q <= next_ptr;
               state_q <= S_WR_CUR;
            end
            S_WR_CUR: begin
               cell_valid_o <= 1'b1;
               st_init_q <= 1'b1;
               state_q <= S_FIN;
            end
            default: begin
               st_done_q <= 1'b1;
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // tcs_engine

// [tcs_consts.vh]
// Constants for the transmit control structure engine.
// Assumes inclusion by bare name from the engine source file only.
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH
// Avalon byte offsets of the engine registers.
`define TCS_REG_CTRL 12'h000
`define TCS_REG_SPTR 12'h004
`define TCS_REG_BASE 12'h008
`define TCS_REG_STAT 12'h00C
`define TCS_REG_HDR 12'h010
`define TCS_REG_BUFA 12'h014
`define TCS_REG_PTRS 12'h018
// Control memory window, one 16-bit structure word per 32-bit slot.
`define TCS_MEM_WIN 1'b1
// Structure word indices (byte offset divided by two).
`define TCS_W_ENTRY 3'h0
`define TCS_W_SIZE 3'h1
`define TCS_W_CUR 3'h2
`define TCS_W_OFS 3'h3
`define TCS_W_HDR_HI 3'h4
`define TCS_W_HDR_LO 3'h5
`define TCS_W_COUNT 3'h6
// Field positions within the structure words.
`define TCS_ACTIVE_BIT 8
`define TCS_INIT_BIT 6
`define TCS_RSVD_BIT 7
`define TCS_VALID_BIT 15
`define TCS_PTI_LSB_BIT 1
// Pointer-byte selection codes.
`define TCS_PSEL_NONE 4'h0
`define TCS_PSEL_STD 4'h8
// Reset values.
`define TCS_RST_ADDR 21'h000000
`define TCS_RST_WORD 16'h0000
`endif

// [tcs_tdm_src.sv]
// Model of the TDM writer that feeds the engine its write pointer.
// Assumes the bench clock and a run enable from the bench.
`timescale 1ns/1ps
module tcs_tdm_src (
   input wire logic mclk_i,
   input wire logic run_i,
   output logic [7:0] wr_ptr_o
);
   // Pointer advances once a cycle while run is high and freezes otherwise.
   initial wr_ptr_o = 8'h00;
   always @(posedge mclk_i) begin
      if (run_i) begin
         wr_ptr_o <= wr_ptr_o + 8'h01;
      end
   end
endmodule // tcs_tdm_src

// [tcs_engine_checker.sv]
// Assertions on the structure engine ports.
// Assumes a bind onto tcs_engine and one clock domain.
`timescale 1ns/1ps
module tcs_engine_checker (
   input wire mclk_i,
   input wire rst_n_i,
   input wire avs_waitrequest_o,
   input wire [31:0] cell_hdr_o,
   input wire [20:0] buf_addr_o,
   input wire cell_oam_o,
   input wire pbyte_now_o,
   input wire [2:0] cell_seq_o,
   input wire cell_valid_o
);
   // All checks share the engine clock and reset.
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_wait_one; $fell(avs_waitrequest_o) |=> avs_waitrequest_o; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_valid_one; cell_valid_o |=> !cell_valid_o; endproperty
   a_valid_one: assert property (p_valid_one) else $error("valid too long");
   property p_valid_busy; cell_valid_o |-> avs_waitrequest_o; endproperty
   a_valid_busy: assert property (p_valid_busy) else $error("cell outside pass");
   property p_oam; cell_oam_o == cell_hdr_o[1]; endproperty
   a_oam: assert property (p_oam) else $error("oam flag wrong");
   // Results are loaded two cycles before the valid pulse and then hold.
   property p_hdr_hold; $changed(cell_hdr_o) |-> ##2 cell_valid_o; endproperty
   a_hdr_hold: assert property (p_hdr_hold) else $error("header moved");
   property p_addr_hold; $changed(buf_addr_o) |-> ##2 cell_valid_o; endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_pb_hold; $changed(pbyte_now_o) |-> ##2 cell_valid_o; endproperty
   a_pb_hold: assert property (p_pb_hold) else $error("pointer flag moved");
   property p_pb_odd; cell_valid_o && cell_seq_o[0] |-> !pbyte_now_o; endproperty
   a_pb_odd: assert property (p_pb_odd) else $error("pointer on odd cell");
   // Main scenarios seen.
   c_cell: cover property (cell_valid_o);
   c_pbyte: cover property (cell_valid_o && pbyte_now_o);
   c_acc: cover property ($fell(avs_waitrequest_o));
endmodule // tcs_engine_checker
bind tcs_engine tcs_engine_checker u_chk (.mclk_i, .rst_n_i, .avs_waitrequest_o, .cell_hdr_o,
   .buf_addr_o, .cell_oam_o, .pbyte_now_o, .cell_seq_o, .cell_valid_o);

// [tb_tx_cell_control_structure.sv]
// Self-checking bench: builds structures in control memory and runs passes.
// Assumes tcs_engine, the checker bind and the TDM writer model.
`timescale 1ns/1ps
module tb_tx_cell_control_structure;
   logic mclk_i, rst_n_i, avs_read_i, avs_write_i, run;
   logic [11:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, cell_hdr_o, rd, seed;
   logic avs_waitrequest_o, cell_oam_o, pbyte_now_o, cell_valid_o;
   logic [7:0] tdm_wr_ptr_i, cell_hec_o, hec;
   logic [20:0] buf_addr_o, base;
   logic [2:0] cell_seq_o;
   logic [5:0] payload_size_o, ptr, np;
   logic [15:0] h8, ha, e1;
   logic [3:0] psel;
   int bad_count = 0, total_checks = 0, nv = 0, v0, k;
   tcs_engine uut (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
      .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .tdm_wr_ptr_i, .cell_hdr_o,
      .cell_hec_o, .buf_addr_o, .cell_oam_o, .pbyte_now_o, .cell_seq_o, .payload_size_o, .cell_valid_o);
   tcs_tdm_src u_tdm (.mclk_i, .run_i(run), .wr_ptr_o(tdm_wr_ptr_i));
   // Clock and cell pulse counter.
   initial begin
      mclk_i = 0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) if (cell_valid_o === 1'b1) nv++;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One Avalon access, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         if (++n > 200) begin
            bad_count++;
            stop_test();
         end
         @(posedge mclk_i);
      end
      rd = avs_readdata_o;
      avs_write_i <= 0;
      avs_read_i <= 0;
      @(posedge mclk_i);
   endtask
   task automatic mw(input logic [11:0] b, input logic [15:0] d);
      bus(1, 12'h800 + b * 2, {16'h0000, d});
   endtask
   // Start a pass with the writer frozen, then read busy and status.
   task automatic pass();
      run <= 0;
      v0 = nv;
      bus(1, 12'h000, 32'h1);
      bus(0, 12'h000, 0);
      chk(rd[0], 1'b0);
      bus(0, 12'h00C, 0);
   endtask
   initial begin
      {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = 0;
      run = 1;
      seed = 32'hEEB32231;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1;
      @(posedge mclk_i);
      bus(1, 12'h004, 32'h140);
      seed = lfsr(seed);
      base = seed[20:0];
      bus(1, 12'h008, {11'h000, base});
      bus(0, 12'h004, 0);
      chk(rd, 32'h140);
      bus(0, 12'h03C, 0);
      chk(rd, 0);
      for (k = 0; k < 2; k++) begin
         run <= 1;
         seed = lfsr(seed);
         {h8, ha} = seed;
         seed = lfsr(seed);
         e1 = {1'b1, seed[14:0]};
         ptr = seed[29:24];
         hec = seed[23:16];
         psel = k ? 4'h8 : 4'h0;
         mw(12'h140, 16'h4D4E);
         mw(12'h142, {hec, 8'hAF});
         mw(12'h144, {10'h130, ptr});
         mw(12'h146, {12'h000, psel});
         mw(12'h148, h8);
         mw(12'h14A, ha);
         mw(12'h14C, e1);
         mw(12'h14E, 16'h7FFF);
         pass();
         chk(rd[2:0], 3'b001);
         chk(nv - v0, 1);
         chk(cell_hdr_o, {h8, ha});
         chk(cell_hec_o, hec);
         chk(buf_addr_o, base + {e1[14:0], 6'h00});
         chk(cell_oam_o, ha[1]);
         chk({cell_seq_o, payload_size_o}, 9'h02F);
         chk(pbyte_now_o, psel[3]);
         np = ptr + 6'h2F;
         bus(0, 12'hA88, 0);
         chk(rd, {16'h0000, 10'h139, np});
         bus(0, 12'hA8C, 0);
         chk(rd, {16'h0000, tdm_wr_ptr_i - {2'b00, np}, 4'h4, psel});
         pass();
         chk(rd[2:0], 3'b101);
         chk(nv - v0, 0);
      end
      mw(12'h140, 16'h4C4E);
      pass();
      chk(rd[1:0], 2'b11);
      chk(nv - v0, 0);
      stop_test();
   end
endmodule // tb_tx_cell_control_structure
